/* File: rtl/pixel_crop_and_shift.sv */
// What this block does
// - Shift zero passes pixels unchanged.
// - Shift settings 1 to 4 select shift.
// - Shift moves bits up, zeroes low bits.
// - Overflowing shifted value saturates to all ones.
// - 8-bit format sends converter bits 11..4.
// - Coordinates start at top left, zero.
// - Window columns from start column, width wide.
// - Window rows from start row, height tall.
// - Forward only pixels inside the window.
// - Start column plus width within sensor.
// - Start row plus height within sensor.
// - Mono default: steps of one, sizes nonzero.
// - Color default: even values, steps of two.
// - Variant: even offsets, sizes multiple four.
// - Variant: column settings multiples of sixteen.
// - Variant: column settings multiples of thirty-two.
// - Variant: minimum window size sixty-four.
// - Binning makes settings virtual columns and rows.
// - Width and height maximum and step readable.
//
// Register access over Wishbone and the address map are this design's own decisions.
`include "pixel_crop_map.svh"

module pixel_crop_and_shift (
	input wire logic mclk,
	input wire logic rst_n,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic pixValid,
	input wire logic pixFrameStart,
	input wire logic pixLineStart,
	input wire logic [11:0] pixData,
	output logic outValid,
	output logic outFrameStart,
	output logic outLineStart,
	output logic [11:0] outData
);
	// Step size of one setting for the given profile and sensor colour.
	function automatic logic [15:0] stepOf(input logic [2:0] prof, input logic color,
		input logic isCol, input logic isSize);
		logic [15:0] base;
		base = color ? 16'h0002 : 16'h0001;
		unique case (prof)
			pixel_crop_pkg::PROF_EVEN4: stepOf = isSize ? 16'h0004 : 16'h0002;
			pixel_crop_pkg::PROF_COL16: stepOf = isCol ? 16'h0010 : base;
			pixel_crop_pkg::PROF_COL32: stepOf = isCol ? 16'h0020 : base;
			default: stepOf = base;
		endcase
	endfunction

	// Least legal value of a setting; offsets may always be zero.
	function automatic logic [15:0] minOf(input logic [2:0] prof, input logic color,
		input logic isCol, input logic isSize);
		if (!isSize)
			minOf = 16'h0000;
		else if (prof == pixel_crop_pkg::PROF_MIN64)
			minOf = 16'h0040;
		else
			minOf = stepOf(prof, color, isCol, isSize);
	endfunction

	// Legal when on the step grid, not below minimum, and inside the sensor.
	function automatic logic fits(input logic [15:0] v, input logic [15:0] step,
		input logic [15:0] least, input logic [15:0] other, input logic [15:0] limit);
		logic [16:0] span;
		span = {1'b0, v} + {1'b0, other};
		fits = ((v & (step - 16'h0001)) == 16'h0000) && (v >= least)
			&& (span <= {1'b0, limit});
	endfunction

	// Byte-lane merge of the low half-word on a write.
	function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
		input logic [3:0] sel);
		merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
	endfunction

	// Software-visible settings and flags.
	logic [15:0] ctrlReg; // Shift, format, centering, colour, binning, profile.
	logic [15:0] startColReg; // First column of the window.
	logic [15:0] startRowReg; // First row of the window.
	logic [15:0] widthReg; // Columns in the window.
	logic [15:0] heightReg; // Rows in the window.
	logic rejectReg; // Sticky: a write was refused.
	logic rejectNext;
	pixel_crop_pkg::window_t activeReg; // Settings in force for the current frame.
	pixel_crop_pkg::window_t pendingSet; // Settings as software last left them.
	pixel_crop_pkg::window_t selSet; // Settings applying to the incoming pixel.
	logic [15:0] colReg; // Column of the next pixel in the line.
	logic [15:0] rowReg; // Row of the current line.
	logic [31:0] readWord; // Read data selected by the address.

	// Decoded control fields.
	wire logic [2:0] prof; // Step-size profile.
	wire logic color; // Colour sensor: even settings.
	wire logic hCenter; // Horizontal auto-centering on.
	wire logic vCenter; // Vertical auto-centering on.
	wire logic [15:0] colLimit; // Sensor columns, virtual under binning.
	wire logic [15:0] rowLimit; // Sensor rows, virtual under binning.
	assign prof = ctrlReg[`PCS_CTRL_PROF_LSB +: 3];
	assign color = ctrlReg[`PCS_CTRL_COLOR];
	assign hCenter = ctrlReg[`PCS_CTRL_HCEN];
	assign vCenter = ctrlReg[`PCS_CTRL_VCEN];
	// Binning by two halves the virtual extent; the stream itself already counts
	// virtual pixels, so the window compare needs no change.
	assign colLimit = ctrlReg[`PCS_CTRL_BINH] ? (`PCS_SENSOR_COLS >> 1) : `PCS_SENSOR_COLS;
	assign rowLimit = ctrlReg[`PCS_CTRL_BINV] ? (`PCS_SENSOR_ROWS >> 1) : `PCS_SENSOR_ROWS;

	// Steps of the four settings.
	wire logic [15:0] scolStep;
	wire logic [15:0] srowStep;
	wire logic [15:0] widthStep;
	wire logic [15:0] heightStep;
	assign scolStep = stepOf(prof, color, 1'b1, 1'b0);
	assign srowStep = stepOf(prof, color, 1'b0, 1'b0);
	assign widthStep = stepOf(prof, color, 1'b1, 1'b1);
	assign heightStep = stepOf(prof, color, 1'b0, 1'b1);

	// Bus decode: writes land on the edge where ack is high.
	wire logic wbReq; // A request is on the bus.
	wire logic wrEn; // Write takes effect at this edge.
	wire logic [15:0] wrLow; // Merged write value for a 16-bit register.
	assign wbReq = wb_cyc_i && wb_stb_i;
	assign wrEn = wbReq && wb_we_i && wb_ack_o;
	wire logic hitCtrl;
	wire logic hitScol;
	wire logic hitSrow;
	wire logic hitWidth;
	wire logic hitHeight;
	wire logic hitStat;
	assign hitCtrl = wb_adr_i == `PCS_OFS_CTRL;
	assign hitScol = wb_adr_i == `PCS_OFS_SCOL;
	assign hitSrow = wb_adr_i == `PCS_OFS_SROW;
	assign hitWidth = wb_adr_i == `PCS_OFS_WIDTH;
	assign hitHeight = wb_adr_i == `PCS_OFS_HEIGHT;
	assign hitStat = wb_adr_i == `PCS_OFS_STAT;
	assign wrLow = hitScol ? merge16(startColReg, wb_dat_i, wb_sel_i)
		: hitSrow ? merge16(startRowReg, wb_dat_i, wb_sel_i)
		: hitWidth ? merge16(widthReg, wb_dat_i, wb_sel_i)
		: hitHeight ? merge16(heightReg, wb_dat_i, wb_sel_i)
		: merge16(ctrlReg, wb_dat_i, wb_sel_i);

	// Acceptance of each write; a refused write leaves the register alone.
	wire logic okCtrl;
	wire logic okScol;
	wire logic okSrow;
	wire logic okWidth;
	wire logic okHeight;
	// Shift amounts above four are not a legal setting.
	assign okCtrl = wrLow[`PCS_CTRL_SHIFT_LSB +: 3] <= `PCS_SHIFT_MAX;
	// While centering owns an offset, software writes to it are refused.
	assign okScol = !hCenter && fits(wrLow, scolStep, 16'h0000, widthReg, colLimit);
	assign okSrow = !vCenter && fits(wrLow, srowStep, 16'h0000, heightReg, rowLimit);
	assign okWidth = fits(wrLow, widthStep, minOf(prof, color, 1'b1, 1'b1),
		startColReg, colLimit);
	assign okHeight = fits(wrLow, heightStep, minOf(prof, color, 1'b0, 1'b1),
		startRowReg, rowLimit);
	wire logic badWrite; // A write to a checked register failed its check.
	assign badWrite = wrEn && ((hitCtrl && !okCtrl) || (hitScol && !okScol)
		|| (hitSrow && !okSrow) || (hitWidth && !okWidth) || (hitHeight && !okHeight));
	// A new refusal in the clearing cycle wins, so no event is lost.
	assign rejectNext = badWrite
		|| (rejectReg && !(wrEn && hitStat && wb_sel_i[0] && wb_dat_i[`PCS_STAT_REJECT]));

	// Read-back of the largest legal width and height, rounded to the grid.
	wire logic [15:0] widthMax;
	wire logic [15:0] heightMax;
	assign widthMax = (colLimit - startColReg) & ~(widthStep - 16'h0001);
	assign heightMax = (rowLimit - startRowReg) & ~(heightStep - 16'h0001);
	// Unmapped addresses read as zero and ignore writes.
	assign readWord = hitCtrl ? {16'h0000, ctrlReg}
		: hitScol ? {16'h0000, startColReg}
		: hitSrow ? {16'h0000, startRowReg}
		: hitWidth ? {16'h0000, widthReg}
		: hitHeight ? {16'h0000, heightReg}
		: (wb_adr_i == `PCS_OFS_WINFO) ? {widthStep, widthMax}
		: (wb_adr_i == `PCS_OFS_HINFO) ? {heightStep, heightMax}
		: hitStat ? {25'h0000000, activeReg.shift, 3'h0, rejectReg}
		: 32'h00000000;

	// Bus answer: one ack a cycle after the request, read data held with it.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h00000000;
		end
		else
		begin
			wb_ack_o <= wbReq && !wb_ack_o;
			wb_dat_o <= readWord;
		end
	end

	// Settings registers; reset leaves a full-sensor window and no shift.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			ctrlReg <= 16'h0000;
			startColReg <= 16'h0000;
			startRowReg <= 16'h0000;
			widthReg <= `PCS_SENSOR_COLS;
			heightReg <= `PCS_SENSOR_ROWS;
			rejectReg <= 1'b0;
		end
		else
		begin
			rejectReg <= rejectNext;
			if (wrEn && hitCtrl && okCtrl)
				ctrlReg <= wrLow;
			if (wrEn && hitScol && okScol)
				startColReg <= wrLow;
			if (wrEn && hitSrow && okSrow)
				startRowReg <= wrLow;
			if (wrEn && hitWidth && okWidth)
				widthReg <= wrLow;
			if (wrEn && hitHeight && okHeight)
				heightReg <= wrLow;
		end
	end

	// Settings are sampled only as a frame begins, so a frame is never mixed.
	assign pendingSet = '{startCol: startColReg, startRow: startRowReg, width: widthReg,
		height: heightReg, shift: ctrlReg[`PCS_CTRL_SHIFT_LSB +: 3],
		fmt8: ctrlReg[`PCS_CTRL_FMT8]};
	wire logic frameBegin;
	assign frameBegin = pixValid && pixFrameStart;
	assign selSet = frameBegin ? pendingSet : activeReg;

	// Coordinates of the incoming pixel, origin at the top left.
	wire logic [15:0] curCol;
	wire logic [15:0] curRow;
	assign curCol = (pixFrameStart || pixLineStart) ? 16'h0000 : colReg;
	assign curRow = pixFrameStart ? 16'h0000
		: pixLineStart ? rowReg + 16'h0001 : rowReg;

	// Window membership; wide sums avoid wrap at the sensor edge.
	wire logic colIn;
	wire logic rowIn;
	wire logic inWin;
	assign colIn = (curCol >= selSet.startCol)
		&& ({1'b0, curCol} < {1'b0, selSet.startCol} + {1'b0, selSet.width});
	assign rowIn = (curRow >= selSet.startRow)
		&& ({1'b0, curRow} < {1'b0, selSet.startRow} + {1'b0, selSet.height});
	assign inWin = colIn && rowIn;

	// Brightness shift of the incoming pixel.
	shift_if sh();
	assign sh.amount = selSet.shift;
	assign sh.fmt8 = selSet.fmt8;
	assign sh.raw = pixData;
	pixel_shifter u_shifter (
		.sh(sh)
	);

	// Frame-boundary capture and position counters.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			activeReg <= '{startCol: 16'h0000, startRow: 16'h0000, width: `PCS_SENSOR_COLS,
				height: `PCS_SENSOR_ROWS, shift: 3'h0, fmt8: 1'b0};
			colReg <= 16'h0000;
			rowReg <= 16'h0000;
		end
		else if (pixValid)
		begin
			if (pixFrameStart)
				activeReg <= pendingSet;
			colReg <= curCol + 16'h0001;
			rowReg <= curRow;
		end
	end

	// Output stage: pixels outside the window never reach the buffer.
	always_ff @(posedge mclk)
	begin
		if (!rst_n)
		begin
			outValid <= 1'b0;
			outFrameStart <= 1'b0;
			outLineStart <= 1'b0;
			outData <= 12'h000;
		end
		else
		begin
			outValid <= pixValid && inWin;
			outFrameStart <= pixValid && inWin && (curCol == selSet.startCol)
				&& (curRow == selSet.startRow);
			outLineStart <= pixValid && inWin && (curCol == selSet.startCol);
			if (pixValid && inWin)
				outData <= sh.result;
		end
	end

	// All checks below run on the pixel clock and stay quiet while reset is held.
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!rst_n);

	// The mask is a net of its own so that a property can take its past value.
	wire logic [11:0] lowMask; // Bits a shift must leave zero.
	assign lowMask = (12'h001 << sh.amount) - 12'h001;

	// Checks on the pixel path, the settings and the bus ack.
	pass_unshifted_a: assert property ($past(pixValid && inWin && selSet.shift == 3'h0
		&& !selSet.fmt8) |-> outData == $past(pixData))
		else $error("unshifted pixel changed");
	low_bits_zero_a: assert property ($past(pixValid && inWin && !sh.saturated)
		|-> (outData & $past(lowMask)) == 12'h000)
		else $error("shifted pixel has nonzero low bits");
	saturate_full_a: assert property ($past(pixValid && inWin && sh.saturated && !sh.fmt8)
		|-> outData == `PCS_FULL12)
		else $error("overflow did not saturate");
	saturate_byte_a: assert property ($past(pixValid && inWin && sh.saturated && sh.fmt8)
		|-> outData == `PCS_FULL8)
		else $error("8-bit overflow did not saturate");
	drop_outside_a: assert property (pixValid && !inWin |=> !outValid)
		else $error("pixel outside window forwarded");
	col_bound_a: assert property ({1'b0, startColReg} + {1'b0, widthReg}
		<= {1'b0, colLimit} || $changed(ctrlReg))
		else $error("column bound broken");
	row_bound_a: assert property ({1'b0, startRowReg} + {1'b0, heightReg}
		<= {1'b0, rowLimit} || $changed(ctrlReg))
		else $error("row bound broken");
	center_lock_a: assert property (wrEn && hitScol && hCenter |=> $stable(startColReg))
		else $error("offset written while centering");
	row_lock_a: assert property (wrEn && hitSrow && vCenter |=> $stable(startRowReg))
		else $error("row offset written while centering");
	frame_hold_a: assert property (!frameBegin |=> $stable(activeReg))
		else $error("settings changed inside a frame");
	bus_ack_a: assert property (wbReq && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("bus ack not one cycle after request");
endmodule // pixel_crop_and_shift

/* File: rtl/pixel_crop_map.svh */
`ifndef PIXEL_CROP_MAP_SVH
`define PIXEL_CROP_MAP_SVH

// Sensor extent in physical columns and rows; plain defaults for this build.
`define PCS_SENSOR_COLS 16'h0280
`define PCS_SENSOR_ROWS 16'h01E0

// Register byte offsets on the Wishbone slave.
`define PCS_OFS_CTRL 8'h00
`define PCS_OFS_SCOL 8'h04
`define PCS_OFS_SROW 8'h08
`define PCS_OFS_WIDTH 8'h0C
`define PCS_OFS_HEIGHT 8'h10
`define PCS_OFS_WINFO 8'h14
`define PCS_OFS_HINFO 8'h18
`define PCS_OFS_STAT 8'h1C

// Control register field positions.
`define PCS_CTRL_SHIFT_LSB 0
`define PCS_CTRL_FMT8 3
`define PCS_CTRL_HCEN 4
`define PCS_CTRL_VCEN 5
`define PCS_CTRL_COLOR 6
`define PCS_CTRL_BINH 7
`define PCS_CTRL_BINV 8
`define PCS_CTRL_PROF_LSB 12

// Status register field positions.
`define PCS_STAT_REJECT 0
`define PCS_STAT_ASHIFT_LSB 4

// Largest legal shift amount and the full-scale output values.
`define PCS_SHIFT_MAX 3'h4
`define PCS_FULL12 12'hFFF
`define PCS_FULL8 12'h0FF
`define PCS_FMT8_DROP 4

`endif

/* File: rtl/pixel_crop_pkg.sv */
package pixel_crop_pkg;
	// Step-size profile selecting how window settings are quantised.
	typedef enum logic [2:0] {
		PROF_DEFAULT = 3'b000,
		PROF_EVEN4 = 3'b001,
		PROF_COL16 = 3'b010,
		PROF_COL32 = 3'b011,
		PROF_MIN64 = 3'b100
	} profile_t;
	// One complete set of window and shift settings.
	typedef struct packed {
		logic [15:0] startCol;
		logic [15:0] startRow;
		logic [15:0] width;
		logic [15:0] height;
		logic [2:0] shift;
		logic fmt8;
	} window_t;
endpackage

/* File: rtl/shift_if.sv */
// Carries one pixel and its shift settings to the shifter and back.
interface shift_if;
	logic [2:0] amount;
	logic fmt8;
	logic [11:0] raw;
	logic [11:0] result;
	logic saturated;
	modport core(input amount, input fmt8, input raw, output result, output saturated);
	modport user(output amount, output fmt8, output raw, input result, input saturated);
endinterface

/* File: rtl/pixel_shifter.sv */
`include "pixel_crop_map.svh"

module pixel_shifter (
	shift_if.core sh
);
	// Base word: the 8-bit format keeps the converter's top eight bits.
	wire logic [11:0] base; // Word before the shift.
	wire logic [15:0] scaled; // Shifted word with headroom to detect overflow.
	wire logic [11:0] fullScale; // Largest value of the output word.
	assign base = sh.fmt8 ? {4'h0, sh.raw[11:`PCS_FMT8_DROP]} : sh.raw;
	// Shifting left fills the low bits with zeros, a multiply by 2^n.
	assign scaled = {4'h0, base} << sh.amount;
	assign fullScale = sh.fmt8 ? `PCS_FULL8 : `PCS_FULL12;
	// Overflow clamps to all ones rather than wrapping to a dark value.
	assign sh.saturated = scaled > {4'h0, fullScale};
	assign sh.result = sh.saturated ? fullScale : scaled[11:0];
endmodule // pixel_shifter

/* File: test/pixel_source_model.sv */
// Sensor readout on the input side and image buffer on the output side.
module pixel_source_model #(
	parameter int COLS = 20,
	parameter int ROWS = 12
) (
	input wire logic clk,
	output logic pixValid,
	output logic pixFrameStart,
	output logic pixLineStart,
	output logic [11:0] pixData,
	input wire logic outValid,
	input wire logic outFrameStart,
	input wire logic outLineStart,
	input wire logic [11:0] outData
);
	timeunit 1ns;
	timeprecision 1ns;

	// Captured output words as {frame start, line start, data}.
	logic [13:0] capQ [$];

	// Pixel value at a sensor position; rows reach high codes for saturation.
	function automatic logic [11:0] pixAt(input int r, input int c);
		return 12'(r * 256 + c * 16 + 7);
	endfunction

	// Idle strobes low from time zero.
	initial
	begin
		pixValid = 1'b0;
		pixFrameStart = 1'b0;
		pixLineStart = 1'b0;
		pixData = 12'hA5A;
	end

	// One frame scanned from the top left pixel, a two cycle gap per line.
	task automatic sendFrame();
		for (int r = 0; r < ROWS; r++)
		begin
			for (int c = 0; c < COLS; c++)
			begin
				@(posedge clk);
				pixValid <= 1'b1;
				pixFrameStart <= 1'(r == 0 && c == 0);
				pixLineStart <= 1'(c == 0);
				pixData <= pixAt(r, c);
			end
			@(posedge clk);
			pixValid <= 1'b0;
			pixFrameStart <= 1'b0;
			pixLineStart <= 1'b0;
			// Data outside a strobe toggles, so a stale value never looks valid.
			pixData <= ~pixData;
			@(posedge clk);
			pixData <= ~pixData;
		end
	endtask

	// The buffer takes every forwarded pixel.
	always @(posedge clk)
	begin
		if (outValid === 1'b1)
		begin
			capQ.push_back({outFrameStart, outLineStart, outData});
		end
	end
endmodule // pixel_source_model

/* File: test/testbench.sv */
`include "pixel_crop_map.svh"

`define CHK(g, e) \
	begin \
		tests_run++; \
		if ((g) !== (e)) \
		begin \
			fails++; \
			$display("[FAIL] %0t ns: got %0h, expected %0h", $time, (g), (e)); \
		end \
	end

// Self-checking bench: bus tasks, a sensor frame source and an output capture.
module testbench;
	timeunit 1ns;
	timeprecision 1ns;

	logic mclk;
	logic rst_n;
	logic cyc, stb, we, ack;
	logic [7:0] adr;
	logic [3:0] sel;
	logic [31:0] wdat, rdat;
	logic pixValid, pixFrameStart, pixLineStart;
	logic [11:0] pixData, outData;
	logic outValid, outFrameStart, outLineStart;
	int fails = 0;
	int tests_run = 0;
	logic [31:0] q;
	// Reset values, with one unmapped address at the end.
	logic [7:0] ra [8] = '{`PCS_OFS_CTRL, `PCS_OFS_SCOL, `PCS_OFS_SROW, `PCS_OFS_WIDTH,
		`PCS_OFS_HEIGHT, `PCS_OFS_WINFO, `PCS_OFS_HINFO, 8'h20};
	logic [31:0] rv [8] = '{32'h0, 32'h0, 32'h0, 32'h280, 32'h1E0, 32'h10280, 32'h101E0, 32'h0};

	pixel_crop_and_shift pixel_crop_and_shift_inst (.mclk(mclk), .rst_n(rst_n),
		.wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel),
		.wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .pixValid(pixValid),
		.pixFrameStart(pixFrameStart), .pixLineStart(pixLineStart), .pixData(pixData),
		.outValid(outValid), .outFrameStart(outFrameStart), .outLineStart(outLineStart),
		.outData(outData));

	pixel_source_model pixel_source_model_inst (.clk(mclk), .pixValid(pixValid),
		.pixFrameStart(pixFrameStart), .pixLineStart(pixLineStart), .pixData(pixData),
		.outValid(outValid), .outFrameStart(outFrameStart), .outLineStart(outLineStart),
		.outData(outData));

	// Clock of 100 ns period.
	initial
	begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end

	// Prints the counts and the verdict, then stops.
	task automatic results();
		$display("checks %0d, mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask

	// One classic cycle; the request holds until ack is sampled high.
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r);
		@(posedge mclk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'h3;
		wdat <= d;
		// No answer time is assumed; a lost ack is left to the watchdog.
		do
		begin
			@(posedge mclk);
		end
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		we <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] r;
		bus(1'b1, a, d, r);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] r);
		bus(1'b0, a, 32'h0, r);
	endtask

	// Clears the sticky flag, writes, then checks the register and the flag.
	task automatic tryw(input logic [7:0] a, input logic [15:0] d, input bit ok);
		logic [31:0] old, r;
		rd(a, old);
		wr(`PCS_OFS_STAT, 32'h1);
		wr(a, {16'h0, d});
		rd(a, r);
		`CHK(r[15:0], ok ? d : old[15:0])
		rd(`PCS_OFS_STAT, r);
		`CHK(r[0], !ok)
	endtask

	// Expected output word: 8-bit format drops four low bits, then shift and clip.
	function automatic logic [11:0] expPix(input logic [11:0] raw, input int sh, input bit f8);
		logic [15:0] v, top;
		v = f8 ? {8'h00, raw[11:4]} : {4'h0, raw};
		v = v << sh;
		top = f8 ? 16'h00FF : 16'h0FFF;
		return (v > top) ? top[11:0] : v[11:0];
	endfunction

	// Sends one frame and compares every captured pixel against the window.
	task automatic frame(input int sc, input int sr, input int w, input int h,
		input int sh, input bit f8);
		int k;
		logic [13:0] e;
		k = 0;
		pixel_source_model_inst.capQ.delete();
		pixel_source_model_inst.sendFrame();
		repeat (3) @(posedge mclk);
		`CHK(pixel_source_model_inst.capQ.size(), w * h)
		for (int r = sr; r < sr + h; r++)
		begin
			for (int c = sc; c < sc + w; c++)
			begin
				e = {r == sr && c == sc, c == sc, expPix(pixel_source_model_inst.pixAt(r, c), sh, f8)};
				if (k < pixel_source_model_inst.capQ.size())
					`CHK(pixel_source_model_inst.capQ[k], e)
				k++;
			end
		end
	endtask

	// Watchdog well beyond the expected few thousand cycles.
	initial
	begin
		repeat (60000) @(posedge mclk);
		fails++;
		results();
	end

	// Main sequence.
	initial
	begin
		rst_n = 1'b0;
		{cyc, stb, we} = 3'b000;
		adr = 8'h00;
		sel = 4'h3;
		wdat = 32'h0;
		repeat (10) @(posedge mclk);
		rst_n <= 1'b1;
		wr(8'h20, 32'hFFFF);
		wr(`PCS_OFS_WINFO, 32'h0);
		for (int i = 0; i < 8; i++)
		begin
			rd(ra[i], q);
			`CHK(q, rv[i])
		end
		tryw(`PCS_OFS_CTRL, 16'h5, 0);
		tryw(`PCS_OFS_CTRL, 16'h4, 1);
		tryw(`PCS_OFS_WIDTH, 16'h0, 0);
		tryw(`PCS_OFS_HEIGHT, 16'h0, 0);
		tryw(`PCS_OFS_WIDTH, 16'h5, 1);
		tryw(`PCS_OFS_SCOL, 16'h27C, 0);
		tryw(`PCS_OFS_SCOL, 16'h27B, 1);
		tryw(`PCS_OFS_HEIGHT, 16'h4, 1);
		tryw(`PCS_OFS_SROW, 16'h1DD, 0);
		tryw(`PCS_OFS_SROW, 16'h1DC, 1);
		tryw(`PCS_OFS_CTRL, 16'h10, 1);
		tryw(`PCS_OFS_SCOL, 16'h4, 0);
		tryw(`PCS_OFS_CTRL, 16'h20, 1);
		tryw(`PCS_OFS_SROW, 16'h4, 0);
		tryw(`PCS_OFS_CTRL, 16'h40, 1);
		tryw(`PCS_OFS_SCOL, 16'h5, 0);
		tryw(`PCS_OFS_SCOL, 16'h4, 1);
		tryw(`PCS_OFS_WIDTH, 16'h7, 0);
		tryw(`PCS_OFS_WIDTH, 16'h6, 1);
		tryw(`PCS_OFS_CTRL, 16'h1000, 1);
		tryw(`PCS_OFS_WIDTH, 16'h6, 0);
		tryw(`PCS_OFS_WIDTH, 16'h8, 1);
		tryw(`PCS_OFS_SROW, 16'h3, 0);
		tryw(`PCS_OFS_CTRL, 16'h2000, 1);
		tryw(`PCS_OFS_WIDTH, 16'h8, 0);
		tryw(`PCS_OFS_WIDTH, 16'h10, 1);
		tryw(`PCS_OFS_SCOL, 16'h8, 0);
		tryw(`PCS_OFS_SCOL, 16'h10, 1);
		tryw(`PCS_OFS_CTRL, 16'h3000, 1);
		tryw(`PCS_OFS_WIDTH, 16'h10, 0);
		tryw(`PCS_OFS_WIDTH, 16'h20, 1);
		tryw(`PCS_OFS_SCOL, 16'h20, 1);
		rd(`PCS_OFS_WINFO, q);
		`CHK(q, 32'h00200260)
		tryw(`PCS_OFS_CTRL, 16'h4000, 1);
		tryw(`PCS_OFS_SROW, 16'h0, 1);
		tryw(`PCS_OFS_HEIGHT, 16'h20, 0);
		tryw(`PCS_OFS_HEIGHT, 16'h40, 1);
		tryw(`PCS_OFS_WIDTH, 16'h40, 1);
		tryw(`PCS_OFS_CTRL, 16'h80, 1);
		rd(`PCS_OFS_WINFO, q);
		`CHK(q, 32'h00010120)
		tryw(`PCS_OFS_WIDTH, 16'h121, 0);
		tryw(`PCS_OFS_CTRL, 16'h100, 1);
		rd(`PCS_OFS_HINFO, q);
		`CHK(q, 32'h000100F0)
		tryw(`PCS_OFS_HEIGHT, 16'hF1, 0);
		// Size before offsets, so each write stays within the sensor.
		wr(`PCS_OFS_CTRL, 32'h0);
		wr(`PCS_OFS_WIDTH, 32'h5);
		wr(`PCS_OFS_HEIGHT, 32'h4);
		wr(`PCS_OFS_SCOL, 32'h3);
		wr(`PCS_OFS_SROW, 32'h2);
		frame(3, 2, 5, 4, 0, 0);
		wr(`PCS_OFS_SCOL, 32'h0);
		wr(`PCS_OFS_SROW, 32'h0);
		wr(`PCS_OFS_WIDTH, 32'h4);
		wr(`PCS_OFS_HEIGHT, 32'hC);
		for (int f = 0; f < 2; f++)
		begin
			for (int s = 1; s <= 4; s++)
			begin
				wr(`PCS_OFS_CTRL, 32'(f * 8 + s));
				frame(0, 0, 4, 12, s, f[0]);
			end
		end
		// A change in mid-frame must wait for the next frame start.
		wr(`PCS_OFS_CTRL, 32'h0);
		fork
			frame(0, 0, 4, 12, 0, 0);
			begin
				repeat (30) @(posedge mclk);
				wr(`PCS_OFS_CTRL, 32'h3);
			end
		join
		frame(0, 0, 4, 12, 3, 0);
		rd(`PCS_OFS_STAT, q);
		`CHK(q[6:4], 3'h3)
		results();
	end
endmodule // testbench
